// File: hw/ocm_consts.svh
// Address map, option bit positions and reset values for the OTP option block.
`ifndef OCM_CONSTS_SVH
`define OCM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Programmer-side address map
// ----------------------------------------------------------------------------
`define OCM_OPT_FIRST 15'h3ff0
`define OCM_OPT_LAST 15'h3ff5
`define OCM_OPT_HOLE 15'h3ff6
`define OCM_PG_PROG_LO 15'h4000
`define OCM_PG_PROG_HI 15'h7fff

// ----------------------------------------------------------------------------
// Operating-mode address map
// ----------------------------------------------------------------------------
`define OCM_IO_TOP 16'h007f
`define OCM_DATA_TOP 16'h017f
`define OCM_CPU_PROG_LO 16'hc000
`define OCM_PROG_BYTES 16384

// ----------------------------------------------------------------------------
// Option bytes and fields
// ----------------------------------------------------------------------------
`define OCM_OPT_COUNT 6
`define OCM_ERASED 8'hff
`define OCM_IDX_MODE 3'h0
`define OCM_IDX_P0 3'h1
`define OCM_IDX_P1 3'h2
`define OCM_B_POR 0
`define OCM_B_DUAL 1
`define OCM_B_RSTO 2
`define OCM_B_WT_LO 4
`define OCM_B_WT_HI 5

`endif

// File: hw/ocm_otp_option_config_map.sv
// OTP program array, option bytes, address mapping and option capture.
`timescale 1ns/1ps
`include "ocm_consts.svh"

module ocm_otp_option_config_map import ocm_pkg::*; #(
  parameter logic [15:0] IO_TOP = `OCM_IO_TOP,
  parameter logic [15:0] DATA_TOP = `OCM_DATA_TOP,
  parameter logic [15:0] PROG_LO = `OCM_CPU_PROG_LO,
  parameter int PROG_BYTES = `OCM_PROG_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic otp_erase,
  input wire logic eprom_mode,
  input wire logic [14:0] pg_addr,
  input wire logic pg_rd,
  input wire logic pg_wr,
  input wire logic [7:0] pg_wdata,
  output logic [7:0] pg_rdata,
  output logic pg_rvalid,
  output logic pg_rinvalid,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output ocm_region_type cpu_region,
  output logic cfg_valid,
  output logic por_en,
  output logic dual_clock,
  output logic rst_pin_out_en,
  output logic osc_delay_sel_hi,
  output logic osc_delay_sel_lo,
  output logic [7:0] port0_pin_pullup_off,
  output logic [7:0] port1_pin_pullup_off
);

  localparam int AW = $clog2(PROG_BYTES);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic [AW-1:0] prog_idx(input logic [15:0] a);
    prog_idx = a[AW-1:0];
  endfunction : prog_idx

  function automatic ocm_region_type region_of(input logic [15:0] a);
    if (a <= IO_TOP) begin
      region_of = ocm_rgn_io;
    end else if (a <= DATA_TOP) begin
      region_of = ocm_rgn_data;
    end else if (a >= PROG_LO) begin
      region_of = ocm_rgn_prog;
    end else begin
      region_of = ocm_rgn_gap;
    end
  endfunction : region_of

  // --------------------------------------------------------------------------
  // Nonvolatile storage
  // --------------------------------------------------------------------------
  // The array and option bytes model one-time cells, so reset leaves them
  // alone; only otp_erase returns them to the blank state.
  logic [7:0] prog_mem [PROG_BYTES];
  logic [7:0] opt_q [`OCM_OPT_COUNT];
  logic [7:0] opt_d [`OCM_OPT_COUNT];

  logic pg_in_opt;
  logic pg_in_prog;
  logic pg_at_hole;
  logic [2:0] opt_sel;
  logic [7:0] opt_cur;
  logic [AW-1:0] pg_idx;

  assign pg_in_opt = (pg_addr >= `OCM_OPT_FIRST) && (pg_addr <= `OCM_OPT_LAST);
  assign pg_in_prog = (pg_addr >= `OCM_PG_PROG_LO) && (pg_addr <= `OCM_PG_PROG_HI);
  assign pg_at_hole = (pg_addr == `OCM_OPT_HOLE);
  assign opt_sel = 3'(pg_addr - `OCM_OPT_FIRST);
  assign opt_cur = opt_q[opt_sel];
  assign pg_idx = prog_idx({1'b0, pg_addr});

  // Programming can only pull cells to zero, so a vacant bit stays one
  // unless a zero is explicitly written into it.
  always_comb begin
    for (int i = 0; i < `OCM_OPT_COUNT; i++) begin
      opt_d[i] = opt_q[i];
    end
    if (otp_erase) begin
      for (int i = 0; i < `OCM_OPT_COUNT; i++) begin
        opt_d[i] = `OCM_ERASED;
      end
    end else if (eprom_mode && pg_wr && pg_in_opt) begin
      opt_d[opt_sel] = opt_cur & pg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `OCM_OPT_COUNT; i++) begin
      opt_q[i] <= opt_d[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (otp_erase) begin
      for (int i = 0; i < PROG_BYTES; i++) begin
        prog_mem[i] <= `OCM_ERASED;
      end
    end else if (eprom_mode && pg_wr && pg_in_prog) begin
      prog_mem[pg_idx] <= prog_mem[pg_idx] & pg_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Programmer read port
  // --------------------------------------------------------------------------
  logic [7:0] pg_rdata_q, pg_rdata_d;
  logic pg_rvalid_q, pg_rvalid_d;
  logic pg_rinvalid_q, pg_rinvalid_d;

  // Unmapped addresses read as blank; there is no signature decode at all.
  always_comb begin
    pg_rdata_d = pg_rdata_q;
    pg_rvalid_d = 1'b0;
    pg_rinvalid_d = 1'b0;
    if (eprom_mode && pg_rd) begin
      pg_rvalid_d = !pg_at_hole;
      pg_rinvalid_d = pg_at_hole;
      if (pg_in_opt) begin
        pg_rdata_d = opt_cur;
      end else if (pg_in_prog) begin
        pg_rdata_d = prog_mem[pg_idx];
      end else begin
        pg_rdata_d = `OCM_ERASED;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pg_rdata_q <= `OCM_ERASED;
      pg_rvalid_q <= 1'b0;
      pg_rinvalid_q <= 1'b0;
    end else begin
      pg_rdata_q <= pg_rdata_d;
      pg_rvalid_q <= pg_rvalid_d;
      pg_rinvalid_q <= pg_rinvalid_d;
    end
  end

  assign pg_rdata = pg_rdata_q;
  assign pg_rvalid = pg_rvalid_q;
  assign pg_rinvalid = pg_rinvalid_q;

  // --------------------------------------------------------------------------
  // Operating-mode read port
  // --------------------------------------------------------------------------
  ocm_region_type rgn_q, rgn_d;
  logic [7:0] cpu_rdata_q, cpu_rdata_d;
  logic cpu_rvalid_q, cpu_rvalid_d;

  always_comb begin
    rgn_d = rgn_q;
    cpu_rdata_d = cpu_rdata_q;
    cpu_rvalid_d = 1'b0;
    if (!eprom_mode && cpu_rd) begin
      cpu_rvalid_d = 1'b1;
      rgn_d = region_of(cpu_addr);
      if (region_of(cpu_addr) == ocm_rgn_prog) begin
        cpu_rdata_d = prog_mem[prog_idx(cpu_addr)];
      end else begin
        cpu_rdata_d = `OCM_ERASED;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rgn_q <= ocm_rgn_io;
      cpu_rdata_q <= `OCM_ERASED;
      cpu_rvalid_q <= 1'b0;
    end else begin
      rgn_q <= rgn_d;
      cpu_rdata_q <= cpu_rdata_d;
      cpu_rvalid_q <= cpu_rvalid_d;
    end
  end

  assign cpu_region = rgn_q;
  assign cpu_rdata = cpu_rdata_q;
  assign cpu_rvalid = cpu_rvalid_q;

  // --------------------------------------------------------------------------
  // Option capture
  // --------------------------------------------------------------------------
  // The copy is taken on the first edge after reset release, never during
  // reset, so a reset edge only ever loads constants.
  ocm_load_type ld_q, ld_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] p0_q, p0_d;
  logic [7:0] p1_q, p1_d;

  always_comb begin
    ld_d = ld_q;
    mode_d = mode_q;
    p0_d = p0_q;
    p1_d = p1_q;
    unique case (ld_q)
      ocm_ld_wait: begin
        mode_d = opt_q[`OCM_IDX_MODE];
        p0_d = opt_q[`OCM_IDX_P0];
        p1_d = opt_q[`OCM_IDX_P1];
        ld_d = ocm_ld_run;
      end
      ocm_ld_run: begin
        ld_d = ocm_ld_run;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ld_q <= ocm_ld_wait;
      mode_q <= `OCM_ERASED;
      p0_q <= `OCM_ERASED;
      p1_q <= `OCM_ERASED;
    end else begin
      ld_q <= ld_d;
      mode_q <= mode_d;
      p0_q <= p0_d;
      p1_q <= p1_d;
    end
  end

  assign cfg_valid = (ld_q == ocm_ld_run);
  assign por_en = mode_q[`OCM_B_POR];
  assign dual_clock = mode_q[`OCM_B_DUAL];
  assign rst_pin_out_en = mode_q[`OCM_B_RSTO];
  assign osc_delay_sel_hi = mode_q[`OCM_B_WT_HI];
  assign osc_delay_sel_lo = mode_q[`OCM_B_WT_LO];
  assign port0_pin_pullup_off = p0_q;
  assign port1_pin_pullup_off = p1_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic all_blank;
  assign all_blank = &{opt_q[0], opt_q[1], opt_q[2], opt_q[3], opt_q[4], opt_q[5]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_PROG_MAP: assert property (
    eprom_mode && pg_rd && pg_in_prog && !pg_wr && !otp_erase
      |=> pg_rvalid && pg_rdata == prog_mem[$past(pg_idx)])
    else $error("program area read mismatch");
  AST_OPT_WIN: assert property (
    eprom_mode && pg_rd && pg_in_opt && !pg_wr && !otp_erase
      |=> pg_rvalid && pg_rdata == opt_q[$past(opt_sel)])
    else $error("option byte read mismatch");
  AST_MODE_BITS: assert property (
    $rose(cfg_valid) && !$past(pg_wr) && !$past(otp_erase)
      |-> por_en == opt_q[0][0] && dual_clock == opt_q[0][1]
          && rst_pin_out_en == opt_q[0][2] && osc_delay_sel_hi == opt_q[0][5]
          && osc_delay_sel_lo == opt_q[0][4])
    else $error("mode option bits not decoded");
  AST_PULLUPS: assert property (
    $rose(cfg_valid) && !$past(pg_wr) && !$past(otp_erase)
      |-> port0_pin_pullup_off == opt_q[1] && port1_pin_pullup_off == opt_q[2])
    else $error("pull-up options not captured");
  AST_ERASE: assert property (
    otp_erase |=> all_blank)
    else $error("erase left an option bit at zero");
  AST_CLEARS_ONLY: assert property (
    eprom_mode && pg_wr && pg_in_opt && !otp_erase
      |=> opt_q[$past(opt_sel)] == ($past(opt_cur) & $past(pg_wdata)))
    else $error("option programming set a bit");
  AST_HOLE: assert property (
    eprom_mode && pg_rd && pg_at_hole |=> !pg_rvalid && pg_rinvalid)
    else $error("hole address gave valid data");
  AST_IO_LOW: assert property (
    !eprom_mode && cpu_rd && cpu_addr <= IO_TOP |=> cpu_rvalid && cpu_region == ocm_rgn_io)
    else $error("low address not in I/O area");
  AST_PROG_HIGH: assert property (
    !eprom_mode && cpu_rd && cpu_addr >= PROG_LO |=> cpu_region == ocm_rgn_prog)
    else $error("top address not in program area");
  AST_HOLD: assert property (
    cfg_valid && $past(cfg_valid)
      |-> $stable(mode_q) && $stable(port0_pin_pullup_off) && $stable(port1_pin_pullup_off))
    else $error("option outputs changed after capture");

endmodule : ocm_otp_option_config_map

// File: hw/ocm_pkg.sv
// Types shared by the OTP option configuration block.
package ocm_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ocm_rgn_io,
    ocm_rgn_data,
    ocm_rgn_gap,
    ocm_rgn_prog
  } ocm_region_type;

  typedef enum logic {
    ocm_ld_wait,
    ocm_ld_run
  } ocm_load_type;

endpackage : ocm_pkg

// File: tb/ocm_otp_option_config_map_tb.sv
// Self-checking bench for the OTP option block.
`timescale 1ns/1ps
`include "ocm_consts.svh"

module ocm_otp_option_config_map_tb import ocm_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic otp_erase = 1'b0;
  logic eprom_mode = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_rd = 1'b0;
  logic [14:0] pg_addr;
  logic pg_rd, pg_wr, pg_rvalid, pg_rinvalid, cpu_rvalid, cfg_valid;
  logic [7:0] pg_wdata, pg_rdata, cpu_rdata, p0_off, p1_off;
  logic por_en, dual_clock, rst_pin_out_en, osc_delay_sel_hi, osc_delay_sel_lo;
  ocm_region_type cpu_region;
  logic [7:0] rd_d;
  logic rd_v, rd_inv;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] mode_b [2] = '{8'hde, 8'h21};
  logic [7:0] p0_b [2] = '{8'h5a, 8'hff};
  logic [7:0] p1_b [2] = '{8'ha5, 8'h00};
  logic [15:0] c_a [9] = '{16'hc000, 16'hffff, 16'hc001, 16'h0000, 16'h007f, 16'h0080,
                           16'h017f, 16'h0180, 16'hbfff};
  logic [7:0] c_d [9] = '{8'h3c, 8'hc3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  ocm_region_type c_r [9] = '{ocm_rgn_prog, ocm_rgn_prog, ocm_rgn_prog, ocm_rgn_io,
                              ocm_rgn_io, ocm_rgn_data, ocm_rgn_data, ocm_rgn_gap, ocm_rgn_gap};

  always #12.5 clk_sys = ~clk_sys;

  ocm_otp_option_config_map i_ocm_otp_option_config_map (
    .clk_sys(clk_sys), .rst_b(rst_b), .otp_erase(otp_erase), .eprom_mode(eprom_mode),
    .pg_addr(pg_addr), .pg_rd(pg_rd), .pg_wr(pg_wr), .pg_wdata(pg_wdata),
    .pg_rdata(pg_rdata), .pg_rvalid(pg_rvalid), .pg_rinvalid(pg_rinvalid),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .cpu_region(cpu_region), .cfg_valid(cfg_valid), .por_en(por_en),
    .dual_clock(dual_clock), .rst_pin_out_en(rst_pin_out_en),
    .osc_delay_sel_hi(osc_delay_sel_hi), .osc_delay_sel_lo(osc_delay_sel_lo),
    .port0_pin_pullup_off(p0_off), .port1_pin_pullup_off(p1_off)
  );

  ocm_prog_model i_ocm_prog_model (
    .clk_sys(clk_sys), .pg_rdata(pg_rdata), .pg_rvalid(pg_rvalid),
    .pg_rinvalid(pg_rinvalid), .pg_addr(pg_addr), .pg_rd(pg_rd), .pg_wr(pg_wr),
    .pg_wdata(pg_wdata)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [15:0] mode_of(input logic [7:0] b);
    return {11'h0, b[`OCM_B_POR], b[`OCM_B_DUAL], b[`OCM_B_RSTO], b[`OCM_B_WT_HI],
            b[`OCM_B_WT_LO]};
  endfunction : mode_of

  task automatic erase_all;
    @(negedge clk_sys);
    otp_erase = 1'b1;
    @(negedge clk_sys);
    otp_erase = 1'b0;
  endtask : erase_all

  task automatic restart;
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({15'h0, cfg_valid}, 16'h0000);
    chk(mode_of({2'h3, osc_delay_sel_hi, osc_delay_sel_lo, 1'b1, rst_pin_out_en,
                 dual_clock, por_en}), 16'h001f);
    rst_b = 1'b1;
    for (int i = 0; i < 4 && cfg_valid !== 1'b1; i++) @(negedge clk_sys);
    chk({15'h0, cfg_valid}, 16'h0001);
  endtask : restart

  task automatic pg_chk(input logic [14:0] a, input logic [7:0] d, input logic inv);
    i_ocm_prog_model.read_byte(a, rd_d, rd_v, rd_inv);
    chk({8'h0, rd_d}, {8'h0, d});
    chk({14'h0, rd_v, rd_inv}, {14'h0, ~inv, inv});
  endtask : pg_chk

  task automatic cpu_chk(input int k);
    @(negedge clk_sys);
    cpu_addr = c_a[k];
    cpu_rd = 1'b1;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    cpu_addr = ~c_a[k];
    chk({8'h0, cpu_rvalid, cpu_rdata[6:0]}, {8'h0, 1'b1, c_d[k][6:0]});
    chk({7'h0, cpu_rdata[7], 6'h0, cpu_region}, {7'h0, c_d[k][7], 6'h0, c_r[k]});
    @(negedge clk_sys);
    chk({15'h0, cpu_rvalid}, 16'h0000);
  endtask : cpu_chk

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    for (int k = 0; k < 2; k++) begin
      erase_all;
      restart;
      chk({p1_off, p0_off}, 16'hffff);
      i_ocm_prog_model.prog_byte(15'h3ff0, mode_b[k]);
      i_ocm_prog_model.prog_byte(15'h3ff1, p0_b[k]);
      i_ocm_prog_model.prog_byte(15'h3ff2, p1_b[k]);
      chk(mode_of({2'h3, osc_delay_sel_hi, osc_delay_sel_lo, 1'b1, rst_pin_out_en,
                   dual_clock, por_en}), 16'h001f);
      pg_chk(15'h3ff0, mode_b[k] | 8'hc8, 1'b0);
      restart;
      chk(mode_of({2'h3, osc_delay_sel_hi, osc_delay_sel_lo, 1'b1, rst_pin_out_en,
                   dual_clock, por_en}), mode_of(mode_b[k]));
      chk({p1_off, p0_off}, {p1_b[k], p0_b[k]});
    end
    // Programming only clears bits, so a second pass of ff leaves the stored 00 byte unchanged.
    i_ocm_prog_model.prog_byte(15'h3ff2, 8'hff);
    i_ocm_prog_model.prog_byte(15'h3ff3, 8'h00);
    pg_chk(15'h3ff2, 8'h00, 1'b0);
    pg_chk(15'h3ff3, 8'hff, 1'b0);
    pg_chk(15'h3ff5, 8'hff, 1'b0);
    pg_chk(15'h3ff6, 8'hff, 1'b1);
    pg_chk(15'h0000, 8'hff, 1'b0);
    i_ocm_prog_model.prog_byte(15'h4000, 8'h3c);
    i_ocm_prog_model.prog_byte(15'h7fff, 8'hc3);
    pg_chk(15'h4000, 8'h3c, 1'b0);
    eprom_mode = 1'b0;
    i_ocm_prog_model.prog_byte(15'h4000, 8'h00);
    i_ocm_prog_model.read_byte(15'h4000, rd_d, rd_v, rd_inv);
    chk({15'h0, rd_v}, 16'h0000);
    for (int k = 0; k < 9; k++) cpu_chk(k);
    close_out;
  end

  initial begin
    #2000000;
    n_mismatch++;
    close_out;
  end
endmodule : ocm_otp_option_config_map_tb

// File: tb/ocm_prog_model.sv
// Behavioural parallel programmer that drives the programming port of the OTP block.
`timescale 1ns/1ps

module ocm_prog_model (
  input wire logic clk_sys,
  input wire logic [7:0] pg_rdata,
  input wire logic pg_rvalid,
  input wire logic pg_rinvalid,
  output logic [14:0] pg_addr,
  output logic pg_rd,
  output logic pg_wr,
  output logic [7:0] pg_wdata
);
  initial begin
    pg_addr = 15'h0000;
    pg_rd = 1'b0;
    pg_wr = 1'b0;
    pg_wdata = 8'h00;
  end

  // --------------------------------------------------------------------------
  // Programming and reading
  // --------------------------------------------------------------------------
  // Vacant option bits are always sent as ones, so a careless image cannot zero them.
  function automatic logic [7:0] vac_mask(input logic [14:0] a);
    case (a)
      15'h3ff0: vac_mask = 8'hc8;
      15'h3ff3, 15'h3ff4, 15'h3ff5: vac_mask = 8'hff;
      default: vac_mask = 8'h00;
    endcase
  endfunction : vac_mask

  task automatic prog_byte(input logic [14:0] a, input logic [7:0] d);
    if ((a >= 15'h3ff0 && a <= 15'h3ff5) || a >= 15'h4000) begin
      @(negedge clk_sys);
      pg_addr = a;
      pg_wdata = d | vac_mask(a);
      pg_wr = 1'b1;
      @(negedge clk_sys);
      pg_wr = 1'b0;
      pg_addr = ~a;
      pg_wdata = ~pg_wdata;
    end
  endtask : prog_byte

  // Reads carry no guard: a deliberate read of the hole is a scenario of the bench.
  task automatic read_byte(input logic [14:0] a, output logic [7:0] d, output logic v,
                           output logic inv);
    @(negedge clk_sys);
    pg_addr = a;
    pg_rd = 1'b1;
    @(negedge clk_sys);
    pg_rd = 1'b0;
    pg_addr = ~a;
    d = pg_rdata;
    v = pg_rvalid;
    inv = pg_rinvalid;
  endtask : read_byte
endmodule : ocm_prog_model
